// File: hdl/rrs_core.sv
// Rotate-right-no-carry and set-all-ones execution unit with APB access
//////////////////////////////////////////////////////////////////////////
// What this block does
// - Rotate file right, bit0 to bit7, flags
// - Destination zero writes accumulator, file kept
// - Destination one writes back to file
// - Access bit zero uses fixed access bank
// - Access bit one uses bank pointer
// - Extended set, access bit zero, low operand: indexed offset
// - Set-file writes all ones, flags kept
// - Set-file banks like rotate
//////////////////////////////////////////////////////////////////////////
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "rrs_consts.svh"
module rrs_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   rrs_mem_if mif();
   rrs_file_mem #(.DEPTH(4096)) u_mem (.pclk(pclk), .mp(mif));

   rrs_pkg::rrs_phase_e ph_r, ph_nxt;
   logic [15:0] opc_r, opc_nxt;
   logic [3:0] bank_pointer_r, bank_pointer_nxt;
   logic xinst_r, xinst_nxt;
   logic [7:0] acc_r, acc_nxt;
   logic [11:0] fsr2_r, fsr2_nxt;
   logic zf_r, zf_nxt, nf_r, nf_nxt, ill_r, ill_nxt;
   logic [11:0] ea_r, ea_nxt;
   logic [7:0] res_r, res_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic mrd_r, mrd_nxt;

   logic is_rot, is_set, a_bit, d_bit;
   logic [7:0] fop;
   logic setup, apb_mem;
   assign is_rot = opc_r[15:10] == `RRS_OP_ROTR_HI;
   assign is_set = opc_r[15:9] == `RRS_OP_SET_ALL_ONES_OP_HI;
   assign d_bit = opc_r[9];
   assign a_bit = opc_r[8];
   assign fop = opc_r[7:0];
   assign setup = psel && !penable;
   // File window: byte index is paddr minus the window base
   assign apb_mem = paddr[11:10] == 2'h1;

   // Effective file address
   function automatic logic [11:0] eff_addr(input logic a, input logic x, input logic [7:0] f,
                                            input logic [3:0] bp, input logic [11:0] f2);
      logic [11:0] r;
      r = {bp, f};
      if (!a) begin
         if (x && f <= `RRS_ILO_LIMIT) begin
            r = 12'(f2 + {4'h0, f});
         end else if (f < `RRS_ACCESS_SPLIT) begin
            r = {4'h0, f};
         end else begin
            r = {`RRS_ACCESS_HI_BANK, f};
         end
      end
      return r;
   endfunction

   always_comb begin
      ph_nxt = ph_r;
      opc_nxt = opc_r;
      bank_pointer_nxt = bank_pointer_r;
      xinst_nxt = xinst_r;
      acc_nxt = acc_r;
      fsr2_nxt = fsr2_r;
      zf_nxt = zf_r;
      nf_nxt = nf_r;
      ill_nxt = ill_r;
      ea_nxt = ea_r;
      res_nxt = res_r;
      prdata_nxt = prdata_r;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      mrd_nxt = 1'b0;
      mif.we = 1'b0;
      mif.waddr = paddr[11:0] - `RRS_ADDR_FILE;
      mif.wdata = pwdata[7:0];
      mif.raddr = 12'(paddr - `RRS_ADDR_FILE);
      // Instruction sequence, one phase per clock
      case (ph_r)
         rrs_pkg::RRS_Q1: begin
            ea_nxt = eff_addr(a_bit, xinst_r, fop, bank_pointer_r, fsr2_r);
            ill_nxt = !(is_rot || is_set);
            ph_nxt = ill_nxt ? rrs_pkg::RRS_IDLE : rrs_pkg::RRS_Q2;
         end
         rrs_pkg::RRS_Q2: begin
            // Q2 borrows the read port; file reads over APB belong to idle time
            mif.raddr = ea_r;
            ph_nxt = rrs_pkg::RRS_Q3;
         end
         rrs_pkg::RRS_Q3: begin
            if (is_rot) begin
               res_nxt = {mif.rdata[0], mif.rdata[7:1]};
            end else begin
               res_nxt = `RRS_ALL_ONES;
            end
            ph_nxt = rrs_pkg::RRS_Q4;
         end
         rrs_pkg::RRS_Q4: begin
            // Flags follow the rotate only; set-file leaves them alone
            if (is_rot) begin
               zf_nxt = res_r == 8'h00;
               nf_nxt = res_r[7];
            end
            if (is_rot && !d_bit) begin
               acc_nxt = res_r;
            end else begin
               mif.we = 1'b1;
               mif.waddr = ea_r;
               mif.wdata = res_r;
            end
            ph_nxt = rrs_pkg::RRS_IDLE;
         end
         default: begin
            ph_nxt = rrs_pkg::RRS_IDLE;
         end
      endcase
      // APB: registers answer in one access cycle, file reads in two
      if (psel && penable && !pready_r) begin
         if (apb_mem && !pwrite && !mrd_r) begin
            mrd_nxt = 1'b1;
         end else begin
            pready_nxt = 1'b1;
            if (pwrite) begin
               case (paddr)
                  `RRS_ADDR_CTRL: begin
                     xinst_nxt = pwdata[`RRS_CTRL_XINST];
                     bank_pointer_nxt = pwdata[`RRS_CTRL_BANK_LSB +: 4];
                     if (pwdata[`RRS_CTRL_START] && ph_r == rrs_pkg::RRS_IDLE) begin
                        ph_nxt = rrs_pkg::RRS_Q1;
                     end
                  end
                  `RRS_ADDR_OPCODE: opc_nxt = pwdata[15:0];
                  `RRS_ADDR_ACC: acc_nxt = pwdata[7:0];
                  `RRS_ADDR_FSR2: fsr2_nxt = pwdata[11:0];
                  default: begin
                     if (apb_mem && ph_r == rrs_pkg::RRS_IDLE) begin
                        mif.we = 1'b1;
                     end else begin
                        pslverr_nxt = 1'b1;
                     end
                  end
               endcase
            end else begin
               case (paddr)
                  `RRS_ADDR_CTRL: prdata_nxt = {24'h0, bank_pointer_r, 2'h0, xinst_r, 1'b0};
                  `RRS_ADDR_OPCODE: prdata_nxt = {16'h0, opc_r};
                  `RRS_ADDR_STATUS: prdata_nxt = {28'h0, ill_r, nf_r, zf_r,
                                                  ph_r != rrs_pkg::RRS_IDLE};
                  `RRS_ADDR_ACC: prdata_nxt = {24'h0, acc_r};
                  `RRS_ADDR_FSR2: prdata_nxt = {20'h0, fsr2_r};
                  default: begin
                     if (apb_mem) begin
                        prdata_nxt = {24'h0, mif.rdata};
                     end else begin
                        prdata_nxt = 32'h0;
                        pslverr_nxt = 1'b1;
                     end
                  end
               endcase
            end
         end
      end
      // Read data holds through the setup cycle of the next transfer
      if (setup) begin
         prdata_nxt = prdata_r;
      end
   end

   // File memory has no reset; software loads it before each run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_r <= rrs_pkg::RRS_IDLE;
         opc_r <= 16'h0000;
         bank_pointer_r <= 4'h0;
         xinst_r <= 1'b0;
         acc_r <= 8'h00;
         fsr2_r <= 12'h000;
         zf_r <= 1'b0;
         nf_r <= 1'b0;
         ill_r <= 1'b0;
         ea_r <= 12'h000;
         res_r <= 8'h00;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         mrd_r <= 1'b0;
      end else begin
         ph_r <= ph_nxt;
         opc_r <= opc_nxt;
         bank_pointer_r <= bank_pointer_nxt;
         xinst_r <= xinst_nxt;
         acc_r <= acc_nxt;
         fsr2_r <= fsr2_nxt;
         zf_r <= zf_nxt;
         nf_r <= nf_nxt;
         ill_r <= ill_nxt;
         ea_r <= ea_nxt;
         res_r <= res_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         mrd_r <= mrd_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
endmodule

// File: hdl/rrs_consts.svh
// Constants for the rotate-right and set-file execution block
`ifndef RRS_CONSTS_SVH
`define RRS_CONSTS_SVH
`define RRS_OP_ROTR_HI 6'h10
`define RRS_OP_SET_ALL_ONES_OP_HI 7'h34
`define RRS_ALL_ONES 8'hFF
`define RRS_ILO_LIMIT 8'h5F
`define RRS_ACCESS_SPLIT 8'h60
`define RRS_ACCESS_HI_BANK 4'hF
`define RRS_ADDR_CTRL 12'h000
`define RRS_ADDR_OPCODE 12'h004
`define RRS_ADDR_STATUS 12'h008
`define RRS_ADDR_ACC 12'h00C
`define RRS_ADDR_FSR2 12'h010
`define RRS_ADDR_FILE 12'h400
`define RRS_CTRL_START 0
`define RRS_CTRL_XINST 1
`define RRS_CTRL_BANK_LSB 4
`define RRS_ST_BUSY 0
`define RRS_ST_ZERO 1
`define RRS_ST_NEG 2
`define RRS_ST_ILLEGAL 3
`endif

// File: hdl/rrs_pkg.sv
// Types for the rotate-right and set-file execution block
package rrs_pkg;
   typedef enum logic [2:0] {
      RRS_IDLE = 3'b000,
      RRS_Q1 = 3'b001,
      RRS_Q2 = 3'b010,
      RRS_Q3 = 3'b011,
      RRS_Q4 = 3'b100
   } rrs_phase_e;
endpackage

// File: hdl/rrs_mem_if.sv
// Port bundle between the core and its file memory
`timescale 1ns/100ps
interface rrs_mem_if;
   logic we;
   logic [11:0] waddr;
   logic [7:0] wdata;
   logic [11:0] raddr;
   logic [7:0] rdata;
   modport core (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: hdl/rrs_file_mem.sv
// File register memory, registered read data
`timescale 1ns/100ps
module rrs_file_mem #(
   parameter int DEPTH = 4096
) (
   input wire logic pclk,
   rrs_mem_if.mem mp
);
   logic [7:0] mem_r [0:DEPTH-1];
   logic [7:0] rdata_r;
   always_ff @(posedge pclk) begin
      if (mp.we) begin
         mem_r[mp.waddr] <= mp.wdata;
      end
      rdata_r <= mem_r[mp.raddr];
   end
   assign mp.rdata = rdata_r;
endmodule

// File: tb/rrs_core_sva.sv
// APB timing and status checks on rrs_core ports
`timescale 1ns/100ps
module rrs_core_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_s; $rose(psel && penable); endsequence
   sequence reg_s; acc_s ##0 paddr < 12'h400; endsequence
   sequence frd_s; acc_s ##0 (paddr >= 12'h400 && !pwrite); endsequence
   AST_RDY_IN_ACC: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   AST_RDY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_REG_LAT: assert property (reg_s |-> ##1 pready)
      else $error("register answer late");
   AST_FILE_RD_LAT: assert property (frd_s |-> ##1 !pready ##1 pready)
      else $error("file read answer not two cycles");
   AST_UNMAP_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   AST_REG_OK: assert property (
      pready && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("register access refused");
   AST_STATUS_RSVD: assert property (
      pready && !pwrite && paddr == 12'h008 |-> prdata[31:4] == 28'h0)
      else $error("status upper bits set");
endmodule
bind rrs_core rrs_core_sva u_rrs_core_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// File: tb/rrs_core_tb_top.sv
// Random instruction bench for rrs_core
`timescale 1ns/100ps
`include "rrs_consts.svh"
module rrs_core_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = 0, fs, ad;
   logic [31:0] pwdata = 0, prdata, rd, st, sd = 32'h552CBCC7;
   logic [7:0] v, f, r, acc, fx;
   logic [3:0] bk;
   logic d, a, x, op, fz, fn;
   int n_mismatch = 0, compares = 0, j;
   rrs_core u_rrs_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   always #5 pclk = ~pclk;
   //////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic close_out;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] ai, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ai;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   //////////////////////////////////////
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      fz = 1'b0;
      fn = 1'b0;
      for (int k = 0; k < 40; k++) begin
         sd = lfsr(sd);
         // First two rotates hit the zero and sign corners
         v = k == 0 ? 8'h00 : k == 1 ? 8'h01 : sd[7:0];
         // Third pass lands on the last indexed offset
         f = k == 2 ? `RRS_ILO_LIMIT : {1'b0, sd[12:8] % 5'd24, 2'b00};
         bk = {2'b00, sd[15:14]};
         {d, a, x} = k == 2 ? {sd[18], 2'b01} : sd[18:16];
         op = k < 2 ? 1'b0 : sd[19];
         fs = {3'b000, sd[26:20], 2'b00};
         acc = sd[31:24];
         r = {v[0], v[7:1]};
         fx = op ? `RRS_ALL_ONES : d ? r : v;
         ad = a ? {bk, f} : x ? fs + f : {4'h0, f};
         apb(1'b1, 12'h400 + ad, {24'h0, v});
         apb(1'b1, 12'h00C, {24'h0, acc});
         apb(1'b1, 12'h010, {20'h0, fs});
         apb(1'b1, 12'h004, op ? {16'h0, `RRS_OP_SET_ALL_ONES_OP_HI, a, f}
                               : {16'h0, `RRS_OP_ROTR_HI, d, a, f});
         apb(1'b1, 12'h000, {24'h0, bk, 2'b00, x, 1'b1});
         for (j = 0; j < 20; j++) begin
            apb(1'b0, 12'h008, 32'h0);
            if (rd[0] === 1'b0) break;
         end
         st = rd;
         chk("busy polls", 32'h1, j);
         apb(1'b0, 12'h400 + ad, 32'h0);
         if (a) begin
            chk("file", fx, rd[7:0]);
         end else if (x) begin
            chk("file", fx, rd[7:0]);
         end else begin
            chk("file", fx, rd[7:0]);
         end
         apb(1'b0, 12'h00C, 32'h0);
         chk("acc", (!op && !d) ? r : acc, rd[7:0]);
         if (!op) begin
            fz = r == 8'h00;
            fn = r[7];
         end
         chk("status", {28'h0, 1'b0, fn, fz, 1'b0}, st);
      end
      // Undecoded opcode: ends at once, flags kept, illegal bit set
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h0000_00A3);
      apb(1'b0, 12'h008, 32'h0);
      chk("illegal", {28'h0, 1'b1, fn, fz, 1'b0}, rd);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl", 32'h0000_00A2, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      close_out();
   end
endmodule
